// File: crbf_pkg.sv
// Package: constants for the program-flow sequencer
package crbf_pkg;
	// -----------------------------------------------------------------
	// Wishbone register map (byte addresses)
	// -----------------------------------------------------------------
	localparam logic [7:0]  ADR_CTRL      = 8'h00; // Run control and halt
	localparam logic [7:0]  ADR_PC        = 8'h04; // Program counter
	localparam logic [7:0]  ADR_TOP       = 8'h08; // Top of parameter stack
	localparam logic [7:0]  ADR_NEXT      = 8'h0C; // Next of parameter stack
	localparam logic [7:0]  ADR_INDEX     = 8'h10; // Index register
	localparam logic [7:0]  ADR_PAGE      = 8'h14; // Code page and saved page
	localparam logic [7:0]  ADR_STATUS    = 8'h18; // Depths and last class
	localparam logic [7:0]  ADR_RSTK_TOP  = 8'h1C; // Return stack entry at top
	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int          CTRL_RUN_BIT  = 0;     // Run enable
	localparam int          OP_CALL_BIT   = 15;    // Clear means call
	localparam int          OP_RET_BIT    = 5;     // Return bit
	localparam int          BLK_HI        = 15;    // Block number top bit
	localparam int          BLK_LO        = 10;    // Block number low bit
	localparam logic [2:0]  OP_BRANCH     = 3'h4;  // Top three bits of branch
	localparam logic [15:0] OP_RPOP       = 16'hBEC7; // Return stack pop word, return bit clear
	// -----------------------------------------------------------------
	// Branch conditions and block selects
	// -----------------------------------------------------------------
	localparam logic [1:0]  CC_ZERO_KEEP  = 2'h0;
	localparam logic [1:0]  CC_ZERO_POP   = 2'h1;
	localparam logic [1:0]  CC_ALWAYS     = 2'h2;
	localparam logic [1:0]  CC_LOOP       = 2'h3;
	localparam logic [1:0]  BS_SAME       = 2'h0;
	localparam logic [1:0]  BS_NEXT       = 2'h1;
	localparam logic [1:0]  BS_ZERO       = 2'h2;
	localparam logic [1:0]  BS_PREV       = 2'h3;
	// -----------------------------------------------------------------
	// Reset values and sizes
	// -----------------------------------------------------------------
	localparam logic [15:0] PC_RST        = 16'h0000;
	localparam int          STK_DEPTH     = 16;    // Stack depth in words
	localparam int          STK_AW        = 4;     // Stack pointer width
	// Sequencer states
	typedef enum logic [1:0] {
		ST_FETCH  = 2'b00,
		ST_SECOND = 2'b01,
		ST_HALT   = 2'b10
	} crbf_state_t;
endpackage

// File: crbf_stack.sv
// Small push/pop stack memory used for return and parameter stacks
`timescale 1ns/1ns
module crbf_stack #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16,
	parameter int AW    = 4
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata,
	output logic      [AW:0]      depth
);
	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	logic [WIDTH-1:0] mem [DEPTH];  // Stack words
	logic [AW-1:0]    sp_r;         // Points at the next free slot
	logic [AW:0]      cnt_r;        // Entries held

	// Top entry, combinational
	assign rdata = mem[sp_r - AW'(1)];
	assign depth = cnt_r;

	// Pointer and count; push and pop together replace the top
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sp_r  <= '0;
			cnt_r <= '0;
		end else if (push && !pop) begin
			sp_r  <= sp_r + AW'(1);
			cnt_r <= cnt_r + (AW+1)'(1);
		end else if (pop && !push) begin
			sp_r  <= sp_r - AW'(1);
			cnt_r <= cnt_r - (AW+1)'(1);
		end
	end

	// Word write
	always_ff @(posedge clk_sys) begin
		if (push && !pop) begin
			mem[sp_r] <= wdata;
		end else if (push && pop) begin
			mem[sp_r - AW'(1)] <= wdata;
		end
	end
endmodule

// File: crbf_core.sv
// Program-flow sequencer: call, return and block-relative branches
`timescale 1ns/1ns

// Summary of operation
// - Sources use values from before the cycle
// - Second cycle uses first-cycle top and next
// - Fetch: next to top, memory to next, swap
// - Bit 15 clear decodes as call
// - Call target is low bits shifted left
// - Call pushes page and index in one cycle
// - Bit 5 in other words performs return
// - Return costs nothing extra when merged
// - No return in call, branch, pop; pop reads index
// - PC bits 15-10 block, 9-0 offset
// - Condition field selects branch test
// - Block field adjusts PC bits 15-10
// - Offset replaces bits 9-1, bit 0 zero
// - Block applied to incremented PC
// - Unconditional branch leaves parameter stack alone
// - Zero test with pop always pops
// - Loop decrements index or pops return stack
module crbf_core (
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Code memory
	output logic      [15:0] code_addr,
	output logic      [7:0]  code_page,
	input  wire logic [15:0] code_data,
	// Data memory fetch for the two-cycle fetch
	output logic      [15:0] mem_addr,
	input  wire logic [15:0] mem_data
);
	import crbf_pkg::*;
	// -----------------------------------------------------------------
	// State
	// -----------------------------------------------------------------
	crbf_state_t  state_r;          // Sequencer state
	logic [15:0]  pc_r;             // Program counter
	logic [15:0]  top_r;            // Top of parameter stack
	logic [15:0]  next_r;           // Next of parameter stack
	logic [15:0]  index_r;          // Index register
	logic [7:0]   code_page_reg_r;  // Current code page
	logic [7:0]   saved_page_reg_r; // Page saved for return
	logic         run_r;            // Software run enable
	logic [1:0]   last_class_r;     // 0 other,1 call,2 branch,3 return
	logic         wb_ack_r;         // Bus answer
	logic [31:0]  wb_dat_r;         // Bus read data
	logic [15:0]  mem_addr_r;       // Fetch address

	// Stack ports
	logic         rs_push;          // Return stack push
	logic         rs_pop;           // Return stack pop
	logic [23:0]  rs_wdata;         // Saved page and index
	logic [23:0]  rs_rdata;         // Top of return stack
	logic [STK_AW:0] rs_depth;      // Return stack fill
	logic         ps_push;          // Parameter stack push
	logic         ps_pop;           // Parameter stack pop
	logic [15:0]  ps_rdata;         // Parameter stack top
	logic [STK_AW:0] ps_depth;      // Parameter stack fill

	// -----------------------------------------------------------------
	// Decode
	// -----------------------------------------------------------------
	logic [15:0]  ir;               // Instruction word
	logic [15:0]  pc_inc;           // Address of following word
	logic         is_call;          // Call word
	logic         is_branch;        // Branch word
	logic [1:0]   branch_cond_field;  // Branch test
	logic [1:0]   block_select_field; // Block adjust
	logic         is_ret;           // Return taken
	logic         is_rpop;          // Return stack pop word
	logic         is_fetch;         // Two-cycle memory fetch word
	logic [15:0]  br_target;        // Branch address
	logic         executing;        // Word executes now
	logic         wb_req;           // Bus request this cycle

	// Block-relative target from incremented PC
	function automatic logic [15:0] branch_addr(input logic [15:0] pcn,
	                                            input logic [1:0] bsel,
	                                            input logic [8:0] ofs);
		logic [5:0] blk;
		blk = pcn[BLK_HI:BLK_LO];
		case (bsel)
			BS_SAME: blk = blk;
			BS_NEXT: blk = blk + 6'h01;
			BS_ZERO: blk = 6'h00;
			BS_PREV: blk = blk - 6'h01;
			default: blk = blk;
		endcase
		return {blk, ofs, 1'b0};
	endfunction

	assign ir                 = code_data;
	assign executing          = run_r && (state_r == ST_FETCH);
	assign pc_inc             = pc_r + 16'h0002;
	assign is_call            = !ir[OP_CALL_BIT];
	assign is_branch          = (ir[15:13] == OP_BRANCH);
	assign branch_cond_field  = ir[12:11];
	assign block_select_field = ir[10:9];
	assign br_target          = branch_addr(pc_inc, block_select_field, ir[8:0]);
	// Return stack pop matched with its return bit masked
	assign is_rpop            = !is_call && !is_branch &&
	                            ((ir & ~(16'h0001 << OP_RET_BIT)) == OP_RPOP);
	// Return bit gives no return in call, branch and pop words
	assign is_ret             = !is_call && !is_branch && !is_rpop && ir[OP_RET_BIT];
	assign is_fetch           = (ir[15:13] == 3'h7) && !ir[OP_RET_BIT];
	assign wb_req             = wb_cyc_i && wb_stb_i && !wb_ack_r;

	// -----------------------------------------------------------------
	// Stacks
	// -----------------------------------------------------------------
	always_comb begin
		rs_push  = 1'b0;
		rs_pop   = 1'b0;
		rs_wdata = {saved_page_reg_r, index_r};
		ps_push  = 1'b0;
		ps_pop   = 1'b0;
		if (executing) begin
			if (is_call) begin
				rs_push = 1'b1;
			end else if (is_branch) begin
				if (branch_cond_field == CC_ZERO_POP) begin
					ps_pop = 1'b1;
				end
				if (branch_cond_field == CC_LOOP && index_r == 16'h0000) begin
					rs_pop = 1'b1;
				end
			end else if (is_ret) begin
				// Return pops into index and saved page
				rs_pop = 1'b1;
			end else if (is_rpop && !ir[OP_RET_BIT]) begin
				// Return bit set turns the pop word into a no-op
				rs_pop = 1'b1;
			end
		end
	end

	crbf_stack #(.WIDTH(24), .DEPTH(STK_DEPTH), .AW(STK_AW)) u_rstack (
		.clk_sys (clk_sys),
		.rst     (rst),
		.push    (rs_push),
		.pop     (rs_pop),
		.wdata   (rs_wdata),
		.rdata   (rs_rdata),
		.depth   (rs_depth)
	);

	crbf_stack #(.WIDTH(16), .DEPTH(STK_DEPTH), .AW(STK_AW)) u_pstack (
		.clk_sys (clk_sys),
		.rst     (rst),
		.push    (ps_push),
		.pop     (ps_pop),
		.wdata   (next_r),
		.rdata   (ps_rdata),
		.depth   (ps_depth)
	);

	// -----------------------------------------------------------------
	// Sequencer state
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= ST_HALT;
		end else begin
			case (state_r)
				ST_HALT:   state_r <= run_r ? ST_FETCH : ST_HALT;
				ST_FETCH:  state_r <= !run_r ? ST_HALT :
				                      (is_fetch && !is_call) ? ST_SECOND : ST_FETCH;
				ST_SECOND: state_r <= ST_FETCH;
				default:   state_r <= ST_HALT;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Program counter and pages
	// -----------------------------------------------------------------
	// All sources sampled before the edge
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pc_r             <= PC_RST;
			code_page_reg_r  <= 8'h00;
			saved_page_reg_r <= 8'h00;
		end else if (wb_req && wb_we_i && wb_adr_i == ADR_PC && wb_sel_i[0]) begin
			pc_r <= wb_dat_i[15:0];
		end else if (wb_req && wb_we_i && wb_adr_i == ADR_PAGE && wb_sel_i[0]) begin
			code_page_reg_r <= wb_dat_i[7:0];
		end else if (executing) begin
			if (is_call) begin
				pc_r             <= {ir[14:0], 1'b0};
				saved_page_reg_r <= code_page_reg_r;
			end else if (is_branch) begin
				case (branch_cond_field)
					CC_ALWAYS:    pc_r <= br_target;
					CC_ZERO_KEEP: pc_r <= (top_r == 16'h0000) ? br_target : pc_inc;
					CC_ZERO_POP:  pc_r <= (top_r == 16'h0000) ? br_target : pc_inc;
					CC_LOOP:      pc_r <= (index_r != 16'h0000) ? br_target : pc_inc;
					default:      pc_r <= pc_inc;
				endcase
			end else if (is_ret) begin
				pc_r             <= index_r;
				code_page_reg_r  <= saved_page_reg_r;
				saved_page_reg_r <= rs_rdata[23:16];
			end else if (!is_fetch) begin
				pc_r <= pc_inc;
			end
		end else if (run_r && state_r == ST_SECOND) begin
			pc_r <= pc_inc;
		end
	end

	// -----------------------------------------------------------------
	// Index register
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			index_r <= 16'h0000;
		end else if (wb_req && wb_we_i && wb_adr_i == ADR_INDEX && wb_sel_i[0]) begin
			index_r <= wb_dat_i[15:0];
		end else if (executing) begin
			if (is_call) begin
				index_r <= pc_inc;
			end else if (is_branch && branch_cond_field == CC_LOOP) begin
				index_r <= (index_r != 16'h0000) ? index_r - 16'h0001 : rs_rdata[15:0];
			end else if (is_ret || (is_rpop && !ir[OP_RET_BIT])) begin
				index_r <= rs_rdata[15:0];
			end
		end
	end

	// -----------------------------------------------------------------
	// Top and next
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		// Fetch address follows whatever top holds after this edge
		mem_addr_r <= top_r;
		if (rst) begin
			top_r      <= 16'h0000;
			next_r     <= 16'h0000;
			mem_addr_r <= 16'h0000;
		end else if (wb_req && wb_we_i && wb_adr_i == ADR_TOP && wb_sel_i[0]) begin
			top_r      <= wb_dat_i[15:0];
			mem_addr_r <= wb_dat_i[15:0];
		end else if (wb_req && wb_we_i && wb_adr_i == ADR_NEXT && wb_sel_i[0]) begin
			next_r <= wb_dat_i[15:0];
		end else if (executing && is_branch && branch_cond_field == CC_ZERO_POP) begin
			// Next to top, stack to next
			top_r      <= next_r;
			next_r     <= ps_rdata;
			mem_addr_r <= next_r;
		end else if (executing && is_fetch && !is_call) begin
			top_r      <= next_r;
			next_r     <= mem_data;
			mem_addr_r <= next_r;
		end else if (run_r && state_r == ST_SECOND) begin
			top_r      <= next_r;
			next_r     <= top_r;
			mem_addr_r <= next_r;
		end
	end

	// -----------------------------------------------------------------
	// Bus slave and status
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			run_r        <= 1'b0;
			last_class_r <= 2'h0;
		end else begin
			if (wb_req && wb_we_i && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
				run_r <= wb_dat_i[CTRL_RUN_BIT];
			end
			if (executing) begin
				last_class_r <= is_call ? 2'h1 : is_branch ? 2'h2 : is_ret ? 2'h3 : 2'h0;
			end
		end
	end

	// Answer one cycle after request, zero for unmapped
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h00000000;
		end else begin
			wb_ack_r <= wb_req;
			case (wb_adr_i)
				ADR_CTRL:     wb_dat_r <= {31'h0, run_r};
				ADR_PC:       wb_dat_r <= {16'h0, pc_r};
				ADR_TOP:      wb_dat_r <= {16'h0, top_r};
				ADR_NEXT:     wb_dat_r <= {16'h0, next_r};
				ADR_INDEX:    wb_dat_r <= {16'h0, index_r};
				ADR_PAGE:     wb_dat_r <= {16'h0, saved_page_reg_r, code_page_reg_r};
				ADR_STATUS:   wb_dat_r <= {16'h0, 2'h0, last_class_r, ps_depth[3:0],
				                           3'h0, rs_depth};
				ADR_RSTK_TOP: wb_dat_r <= {8'h0, rs_rdata};
				default:      wb_dat_r <= 32'h00000000;
			endcase
		end
	end

	assign wb_ack_o  = wb_ack_r;
	assign wb_dat_o  = wb_dat_r;
	assign code_addr = pc_r;
	assign code_page = code_page_reg_r;
	assign mem_addr  = mem_addr_r;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	a_call_target: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_call && !wb_req) |=> pc_r == {$past(ir[14:0]), 1'b0})
		else $error("call target wrong");
	a_call_index: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_call && !wb_req) |=> index_r == $past(pc_r) + 16'h0002)
		else $error("call return address wrong");
	a_ret_page: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_ret && !wb_req) |=> code_page_reg_r == $past(saved_page_reg_r))
		else $error("return page wrong");
	a_uncond_br: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_branch && branch_cond_field == CC_ALWAYS && !wb_req)
		|=> pc_r == $past(br_target) && top_r == $past(top_r))
		else $error("unconditional branch wrong");
	a_pop_branch: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_branch && branch_cond_field == CC_ZERO_POP && !wb_req)
		|=> top_r == $past(next_r))
		else $error("pop branch did not pop");
	a_loop_dec: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_branch && branch_cond_field == CC_LOOP && index_r != 16'h0000
		 && !wb_req) |=> index_r == $past(index_r) - 16'h0001)
		else $error("loop decrement wrong");
	a_fall_through: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_branch && branch_cond_field == CC_ZERO_KEEP && top_r != 16'h0000
		 && !wb_req) |=> pc_r == $past(pc_r) + 16'h0002)
		else $error("untaken branch wrong");
	a_fetch_swap: assert property (@(posedge clk_sys) disable iff (rst)
		(executing && is_fetch && !is_call && !wb_req) ##1 !wb_req
		|=> next_r == $past(next_r, 2))
		else $error("fetch swap wrong");
endmodule

// File: crbf_code_mem.sv
// Code and data memory model facing the program-flow sequencer
`timescale 1ns/1ns
module crbf_code_mem (
	input  wire logic [15:0] code_addr,
	input  wire logic [7:0]  code_page,
	output logic      [15:0] code_data,
	input  wire logic [15:0] mem_addr,
	output logic      [15:0] mem_data
);
	// -----------------------------------------------------------------
	// Storage
	// -----------------------------------------------------------------
	logic [15:0] prog [logic [15:0]]; // Loaded words by byte address
	int          gen;                 // Bumped so lookups rerun

	// Unloaded words branch to themselves, so the core parks there
	function automatic logic [15:0] self_branch(input logic [15:0] a);
		logic [15:0] n;
		n = a + 16'h0002;
		return {3'b100, 2'b10, (n[15:10] == a[15:10]) ? 2'b00 : 2'b11, a[9:1]};
	endfunction

	// Load one instruction word
	task automatic load(input logic [15:0] a, input logic [15:0] w);
		prog[a] = w;
		gen++;
	endtask

	// Forget every loaded word
	task automatic clear();
		prog.delete();
		gen++;
	endtask

	// Instruction word for the current program counter
	always @(code_addr or gen or code_page) begin
		if (prog.exists(code_addr)) begin
			code_data = prog[code_addr];
		end else begin
			code_data = self_branch(code_addr);
		end
	end

	// Data memory: a fixed scramble of the address
	assign mem_data = mem_addr ^ 16'hA5C3;
	initial gen = 0;
endmodule

// File: tb_top.sv
// Self-checking testbench for the program-flow sequencer
`timescale 1ns/1ns
module tb_top;
	import crbf_pkg::*;
	// -----------------------------------------------------------------
	// Signals
	// -----------------------------------------------------------------
	logic        clk_sys = 1'b0; // 20 MHz system clock
	logic        rst     = 1'b1; // Synchronous reset
	logic        cyc     = 1'b0; // Bus cycle
	logic        stb     = 1'b0; // Bus strobe
	logic        we      = 1'b0; // Bus write
	logic [7:0]  adr     = 8'h00; // Bus address
	logic [31:0] wdat    = 32'h0; // Bus write data
	logic [31:0] rdat;            // Bus read data
	logic        ack;             // Bus acknowledge
	logic [15:0] code_addr;       // Program counter
	logic [7:0]  code_page;       // Code page
	logic [15:0] code_data;       // Instruction word
	logic [15:0] mem_addr;        // Data address
	logic [15:0] mem_data;        // Data word
	int          n_errors   = 0;  // Mismatches
	int          num_checks = 0;  // Comparisons

	always #25 clk_sys = ~clk_sys;

	crbf_core dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .code_addr(code_addr),
		.code_page(code_page), .code_data(code_data), .mem_addr(mem_addr),
		.mem_data(mem_data));

	crbf_code_mem u_mem (.code_addr(code_addr), .code_page(code_page),
		.code_data(code_data), .mem_addr(mem_addr), .mem_data(mem_data));

	// -----------------------------------------------------------------
	// Bus and compare tasks
	// -----------------------------------------------------------------
	// One classic cycle; holds everything until ack is sampled
	task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			n_errors++;
			$display("MISMATCH bus_ack expected 1 seen timeout");
		end
	endtask

	// Compare one value
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Register write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wbx(1'b1, a, d, q);
	endtask

	// Register read and compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		wbx(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask

	// Halt, preset state, run until parked, halt again
	task automatic run_at(input logic [15:0] pc, input logic [15:0] t,
			input logic [15:0] n, input logic [15:0] idx);
		wr(ADR_CTRL, 32'h0);
		wr(ADR_PC, {16'h0, pc});
		wr(ADR_TOP, {16'h0, t});
		wr(ADR_NEXT, {16'h0, n});
		wr(ADR_INDEX, {16'h0, idx});
		wr(ADR_CTRL, 32'h1);
		repeat (16) @(posedge clk_sys);
		wr(ADR_CTRL, 32'h0);
	endtask

	// -----------------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------------
	// Reset state and an unmapped address
	task automatic t_reset();
		rchk(ADR_PC, 32'h0, "pc_reset");
		rchk(ADR_CTRL, 32'h0, "ctrl_reset");
		rchk(8'h40, 32'h0, "unmapped_read");
	endtask

	// Call, then a return merged into an ordinary word
	task automatic t_call_ret();
		logic [31:0] q;
		u_mem.clear();
		u_mem.load(16'h0100, 16'h2A45);
		// new page set ahead of the call
		wr(ADR_PAGE, 32'h3);
		run_at(16'h0100, 16'h0, 16'h0, 16'h0055);
		rchk(ADR_PC, 32'h548A, "call_target");
		rchk(ADR_INDEX, 32'h0102, "call_index");
		rchk(ADR_PAGE, 32'h0303, "call_page");
		rchk(ADR_RSTK_TOP, 32'h0055, "call_push");
		wbx(1'b0, ADR_STATUS, 32'h0, q);
		chk("rstack_depth_call", 32'h1, {27'h0, q[4:0]});
		chk("call_page_pin", 32'h3, {24'h0, code_page});
		u_mem.load(16'h548A, 16'hA020);
		wr(ADR_PAGE, 32'h5);
		run_at(16'h548A, 16'h0, 16'h0, 16'h0102);
		rchk(ADR_PC, 32'h0102, "ret_pc");
		rchk(ADR_INDEX, 32'h0055, "ret_index");
		rchk(ADR_PAGE, 32'h0003, "ret_page");
		chk("ret_page_pin", 32'h3, {24'h0, code_page});
	endtask

	// Return bit inside a call word, then the loop with index zero
	task automatic t_call_bit5_loop();
		u_mem.clear();
		u_mem.load(16'h0200, 16'h0020);
		run_at(16'h0200, 16'h0, 16'h0, 16'h0077);
		rchk(ADR_PC, 32'h0040, "call_bit5_pc");
		rchk(ADR_INDEX, 32'h0202, "call_bit5_index");
		u_mem.load(16'h0C10, {3'b100, CC_LOOP, BS_SAME, 9'h0AB});
		run_at(16'h0C10, 16'h0, 16'h0, 16'h0000);
		rchk(ADR_PC, 32'h0C12, "loop_exit_pc");
		rchk(ADR_INDEX, 32'h0077, "loop_exit_index");
		run_at(16'h0C10, 16'h0, 16'h0, 16'h0002);
		rchk(ADR_PC, 32'h0D56, "loop_taken_pc");
		rchk(ADR_INDEX, 32'h0001, "loop_taken_index");
	endtask

	// Unconditional branch with each block select, and a block edge
	task automatic t_uncond();
		logic [15:0] exp_pc [5] = '{16'h0D56, 16'h1156, 16'h0156, 16'h0956, 16'h0956};
		logic [15:0] at;
		for (int i = 0; i < 5; i++) begin
			at = (i == 4) ? 16'h07FE : 16'h0C10;
			u_mem.clear();
			u_mem.load(at, {3'b100, CC_ALWAYS, 2'(i % 4), 9'h0AB});
			run_at(at, 16'h5555, 16'h6666, 16'h0);
			rchk(ADR_PC, {16'h0, exp_pc[i]}, "uncond_pc");
			rchk(ADR_TOP, 32'h5555, "uncond_top");
			rchk(ADR_NEXT, 32'h6666, "uncond_next");
		end
	endtask

	// Zero tests, keeping or popping, taken and not taken
	task automatic t_zero();
		logic [15:0] t;
		for (int i = 0; i < 4; i++) begin
			t = i[0] ? 16'h0007 : 16'h0000;
			u_mem.clear();
			u_mem.load(16'h0C10, {3'b100, 2'(i >> 1), BS_SAME, 9'h0AB});
			run_at(16'h0C10, t, 16'h1111, 16'h0);
			rchk(ADR_PC, i[0] ? 32'h0C12 : 32'h0D56, "zero_pc");
			rchk(ADR_TOP, (i >> 1) ? 32'h1111 : {16'h0, t}, "zero_top");
		end
	endtask

	// Two-cycle fetch replaces top with the addressed word
	task automatic t_fetch();
		u_mem.clear();
		u_mem.load(16'h0400, 16'hE000);
		run_at(16'h0400, 16'h1234, 16'h00AB, 16'h0);
		rchk(ADR_TOP, 32'hB7F7, "fetch_top");
		rchk(ADR_NEXT, 32'h00AB, "fetch_next");
		rchk(ADR_PC, 32'h0402, "fetch_pc");
		chk("fetch_addr_pin", 32'hB7F7, {16'h0, mem_addr});
		u_mem.load(16'h0402, 16'hE000);
		run_at(16'h0400, 16'h1234, 16'h00AB, 16'h0);
		rchk(ADR_TOP, 32'h1234, "fetch2_top");
		rchk(ADR_NEXT, 32'h00AB, "fetch2_next");
		rchk(ADR_PC, 32'h0404, "fetch2_pc");
	endtask

	// Return stack pop word, with and without the return bit
	task automatic t_rpop();
		logic [31:0] q;
		u_mem.clear();
		u_mem.load(16'h0300, 16'h0300);
		u_mem.load(16'h0600, OP_RPOP | 16'h0020);
		u_mem.load(16'h0700, OP_RPOP);
		run_at(16'h0300, 16'h0, 16'h0, 16'h0099);
		rchk(ADR_PC, 32'h0602, "rpop_ret_bit_pc");
		rchk(ADR_INDEX, 32'h0302, "rpop_ret_bit_index");
		wbx(1'b0, ADR_STATUS, 32'h0, q);
		chk("rpop_ret_bit_depth", 32'h1, {27'h0, q[4:0]});
		run_at(16'h0700, 16'h0, 16'h0, 16'h0302);
		rchk(ADR_INDEX, 32'h0099, "rpop_index");
		rchk(ADR_PC, 32'h0702, "rpop_pc");
	endtask

	// -----------------------------------------------------------------
	// Verdict and run control
	// -----------------------------------------------------------------
	// Print counts and verdict, then stop
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#(50 * 30000);
		n_errors++;
		final_report();
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_call_ret();
		t_call_bit5_loop();
		t_uncond();
		t_zero();
		t_fetch();
		t_rpop();
		final_report();
	end
endmodule
